// ### video_refresh_pkg.sv
// Purpose: shared constants and types for the video refresh config block
// Assumes: 32-bit register port, byte offsets
// Notes: fraction width of the scaler offset is a plain default
package video_refresh_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CFG = 12'h05C;
  localparam logic [11:0] OFS_CURPAT = 12'h060;
  localparam logic [11:0] OFS_VINFMT = 12'h070;
  localparam logic [11:0] OFS_HSTEP = 12'h0A4;
  localparam logic [11:0] OFS_VSTEP = 12'h0AC;
  localparam logic [11:0] OFS_VOFS = 12'h0E0;
  localparam logic [11:0] OFS_CUROVL = 12'h0FC;
  localparam logic [11:0] OFS_LEFT = 12'h100;
  localparam logic [11:0] OFS_RIGHT = 12'h104;
  localparam logic [11:0] OFS_STATUS = 12'h108;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] VINFMT_RESET = 32'h0000_0000;
  localparam int B_STEREO = 2;
  localparam int B_DESK_EN = 7;
  localparam int B_OVL_EN = 8;
  localparam int B_VIN_OVL = 9;
  localparam int B_DESK_BYP = 10;
  localparam int B_OVL_BYP = 11;
  localparam int B_DESK_HI = 12;
  localparam int B_OVL_HI = 13;
  localparam int B_HSCALE = 14;
  localparam int B_VSCALE = 15;
  localparam int B_FILT_LO = 16;
  localparam int B_DFMT_LO = 18;
  localparam int B_OFMT_LO = 21;
  localparam int B_DESK_TILE = 24;
  localparam int B_OVL_TILE = 25;
  localparam int B_TWO_PIX = 26;
  localparam int B_CURSOR = 27;
  localparam int B_DESK_NOOPT = 28;
  localparam int B_OVL_NOOPT = 29;
  localparam int B_BOB = 31;
  localparam int B_WEAVE = 4;
  localparam int B_VS_POL = 5;
  localparam int B_HS_POL = 6;
  localparam int ST_FRAME = 0;
  localparam int ST_STEREO = 1;
  localparam int ST_PEND = 2;
  localparam int ST_CFETCH = 3;
  localparam int OFS_W = 19;
  localparam int OFS_FRAC = 12;
  localparam logic [18:0] OFS_HALF = 19'h00800;
  localparam int CUR_WORDS = 8;
  localparam logic [25:0] CUR_WORD_BYTES = 26'h0000010;
  typedef enum logic [1:0] {F_POINT, F_BOX2X2, F_TAP4X1, F_BILINEAR} filter_e;
  typedef enum logic [2:0] {D_PAL8, D_RGB565, D_RGB24, D_RGB32, D_RGB1555,
    D_RSV5, D_RSV6, D_RSV7} desk_fmt_e;
  typedef enum logic [2:0] {O_1555D, O_565U, O_1555U, O_RGB32, O_YUV411,
    O_YUYV, O_UYVY, O_565D} ovl_fmt_e;
  typedef struct packed {
    logic desk_fetch;
    logic ovl_fetch;
    logic desk_tiled;
    logic ovl_tiled;
    logic two_pix;
    logic cursor_on;
    logic desk_noopt;
    logic ovl_noopt;
    logic h_scale;
    logic v_scale;
    filter_e filter;
    desk_fmt_e desk_fmt;
    logic desk_fmt_bad;
    logic [2:0] desk_bytes;
    ovl_fmt_e ovl_fmt;
    logic ovl_yuv;
  } refresh_ctrl_s;
  typedef struct packed {
    logic [63:0] pat1;
    logic [63:0] pat0;
  } cursor_word_s;
endpackage

// ### video_refresh_surface_config.sv
// Purpose: video refresh processor configuration, stereo and cursor fetch
// Assumes: all inputs synchronous to mclk_i; retrace inputs are pulses
// Notes: pending stereo pair holds a single entry
// Summary of operation
// - fetch desktop/overlay only when enabled
// - video-in address replaces overlay address
// - palette bypass per layer
// - palette half select per layer
// - overlay scaling per axis enable
// - overlay filter mode decode
// - desktop pixel format decode
// - overlay pixel format decode
// - tiled or linear per surface
// - one or two pixels per clock
// - cursor overlaid only when enabled
// - memory optimisation disables, reset zero
// - bob adds half offset on even field in one-pixel mode
// - swap pushes left/right pair
// - new pair applies after right frame in stereo mode, left address at next retrace with stereo off
// - stereo pin shows field, low when off
// - cursor word holds both pattern lines
// - eight cursor words fetched per hit
// - weave merges two input fields
// - input sync polarity select
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module video_refresh_surface_config
  import video_refresh_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic vretrace_i,
  input wire logic hretrace_i,
  input wire logic even_field_i,
  input wire logic swap_i,
  input wire logic [25:0] vin_addr_i,
  input wire logic [7:0] pix_index_i,
  input wire logic pix_is_ovl_i,
  input wire logic cursor_hit_i,
  input wire logic [5:0] cursor_row_i,
  input wire logic cur_ack_i,
  input wire logic [127:0] cur_data_i,
  input wire logic vin_field_done_i,
  input wire logic vin_vsync_i,
  input wire logic vin_hsync_i,
  output refresh_ctrl_s ctrl_o,
  output logic [25:0] ovl_addr_o,
  output logic [OFS_W-1:0] vofs_o,
  output logic [8:0] clut_addr_o,
  output logic clut_bypass_o,
  output logic stereo_o,
  output logic cur_req_o,
  output logic [25:0] cur_addr_o,
  output cursor_word_s cur_line_o,
  output logic cur_show_o,
  output logic vin_vsync_o,
  output logic vin_hsync_o,
  output logic vin_frame_o
);
  typedef enum logic {C_IDLE, C_FETCH} cfetch_e;
  logic [31:0] cfg;
  logic [31:0] vinfmt;
  logic [25:0] curpat;
  logic [19:0] hstep;
  logic [19:0] vstep;
  logic [OFS_W-1:0] vofs;
  logic [25:0] left_wr;
  logic [25:0] right_wr;
  logic [25:0] act_left;
  logic [25:0] act_right;
  logic [25:0] pend_left;
  logic [25:0] pend_right;
  logic pend_valid;
  logic frame_flag;
  logic weave_half;
  logic vin_frame_ev;
  cfetch_e cstate;
  logic [2:0] fcount;
  logic [2:0] rd_ptr;
  logic [3:0] lines_left;
  cursor_word_s cur_ram [CUR_WORDS];
  logic [31:0] next_rdata;
  logic [25:0] next_ovl;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // register writes
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg <= CFG_RESET;
      vinfmt <= VINFMT_RESET;
      curpat <= '0;
      hstep <= '0;
      vstep <= '0;
      vofs <= '0;
      left_wr <= '0;
      right_wr <= '0;
    end else if (wr_i) begin
      unique case (addr_i)
        OFS_CFG: cfg <= wdata_i;
        OFS_VINFMT: vinfmt <= wdata_i;
        OFS_CURPAT: curpat <= wdata_i[25:0];
        OFS_HSTEP: hstep <= wdata_i[19:0];
        OFS_VSTEP: vstep <= wdata_i[19:0];
        OFS_VOFS: vofs <= wdata_i[OFS_W-1:0];
        OFS_LEFT: left_wr <= wdata_i[25:0];
        OFS_RIGHT: right_wr <= wdata_i[25:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped reads as zero
  always_comb begin
    next_rdata = '0;
    unique case (addr_i)
      OFS_CFG: next_rdata = cfg;
      OFS_VINFMT: next_rdata = vinfmt;
      OFS_CURPAT: next_rdata[25:0] = curpat;
      OFS_HSTEP: next_rdata[19:0] = hstep;
      OFS_VSTEP: next_rdata[19:0] = vstep;
      OFS_VOFS: next_rdata[OFS_W-1:0] = vofs;
      OFS_CUROVL: next_rdata[25:0] = ovl_addr_o;
      OFS_LEFT: next_rdata[25:0] = left_wr;
      OFS_RIGHT: next_rdata[25:0] = right_wr;
      OFS_STATUS: begin
        next_rdata[ST_FRAME] = frame_flag;
        next_rdata[ST_STEREO] = stereo_o;
        next_rdata[ST_PEND] = pend_valid;
        next_rdata[ST_CFETCH] = (cstate == C_FETCH);
      end
      default: ;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
    end
  end

  // surface and format controls, registered to the pipe
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o.desk_fetch <= cfg[B_DESK_EN];
      ctrl_o.ovl_fetch <= cfg[B_OVL_EN];
      ctrl_o.desk_tiled <= cfg[B_DESK_TILE];
      ctrl_o.ovl_tiled <= cfg[B_OVL_TILE];
      ctrl_o.two_pix <= cfg[B_TWO_PIX];
      ctrl_o.cursor_on <= cfg[B_CURSOR];
      ctrl_o.desk_noopt <= cfg[B_DESK_NOOPT];
      ctrl_o.ovl_noopt <= cfg[B_OVL_NOOPT];
      ctrl_o.h_scale <= cfg[B_HSCALE];
      ctrl_o.v_scale <= cfg[B_VSCALE];
      ctrl_o.filter <= filter_e'(cfg[B_FILT_LO+:2]);
      ctrl_o.desk_fmt <= desk_fmt_e'(cfg[B_DFMT_LO+:3]);
      ctrl_o.desk_fmt_bad <= cfg[B_DFMT_LO+2] & (cfg[B_DFMT_LO+:2] != 2'h0);
      unique case (desk_fmt_e'(cfg[B_DFMT_LO+:3]))
        D_PAL8: ctrl_o.desk_bytes <= 3'h1;
        D_RGB565, D_RGB1555: ctrl_o.desk_bytes <= 3'h2;
        D_RGB24: ctrl_o.desk_bytes <= 3'h3;
        D_RGB32: ctrl_o.desk_bytes <= 3'h4;
        default: ctrl_o.desk_bytes <= 3'h0;
      endcase
      ctrl_o.ovl_fmt <= ovl_fmt_e'(cfg[B_OFMT_LO+:3]);
      ctrl_o.ovl_yuv <= cfg[B_OFMT_LO+2] & (cfg[B_OFMT_LO+:2] != 2'h3);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      clut_addr_o <= '0;
      clut_bypass_o <= 1'b0;
    end else if (pix_is_ovl_i) begin
      clut_addr_o <= {cfg[B_OVL_HI], pix_index_i};
      clut_bypass_o <= cfg[B_OVL_BYP];
    end else begin
      clut_addr_o <= {cfg[B_DESK_HI], pix_index_i};
      clut_bypass_o <= cfg[B_DESK_BYP];
    end
  end

  // bob offset; ignored in two-pixel mode, no bilinear there
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      vofs_o <= '0;
    end else if (cfg[B_BOB] && even_field_i && !cfg[B_TWO_PIX]) begin
      vofs_o <= vofs + OFS_HALF;
    end else begin
      vofs_o <= vofs;
    end
  end

  // swap pushes the pair; a later swap overwrites an unused one
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pend_left <= '0;
      pend_right <= '0;
      pend_valid <= 1'b0;
    end else if (swap_i) begin
      pend_left <= left_wr;
      pend_right <= right_wr;
      pend_valid <= 1'b1;
    end else if (vretrace_i && (stereo_o || !cfg[B_STEREO])) begin
      pend_valid <= 1'b0;
    end
  end

  // in stereo mode the pair takes effect only after the right field; with stereo off only the left address loads, at any retrace
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      act_left <= '0;
      act_right <= '0;
      stereo_o <= 1'b0;
    end else if (!cfg[B_STEREO]) begin
      stereo_o <= 1'b0;
      if (vretrace_i && pend_valid) begin
        act_left <= pend_left;
      end
    end else if (vretrace_i) begin
      stereo_o <= !stereo_o;
      if (stereo_o && pend_valid) begin
        act_left <= pend_left;
        act_right <= pend_right;
      end
    end
  end

  always_comb begin
    if (cfg[B_VIN_OVL]) begin
      next_ovl = vin_addr_i;
    end else if (cfg[B_STEREO] && stereo_o) begin
      next_ovl = act_right;
    end else begin
      next_ovl = act_left;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ovl_addr_o <= '0;
    end else begin
      ovl_addr_o <= next_ovl;
    end
  end

  // cursor fetch sequencer, linear addressing only
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cstate <= C_IDLE;
      fcount <= '0;
      cur_req_o <= 1'b0;
      cur_addr_o <= '0;
    end else begin
      unique case (cstate)
        C_IDLE: begin
          if (hretrace_i && cfg[B_CURSOR] && cursor_hit_i && lines_left == 4'h0) begin
            cstate <= C_FETCH;
            fcount <= '0;
            cur_req_o <= 1'b1;
            cur_addr_o <= curpat + 26'(cursor_row_i) * CUR_WORD_BYTES;
          end
        end
        C_FETCH: begin
          if (cur_ack_i) begin
            fcount <= fcount + 3'h1;
            cur_addr_o <= cur_addr_o + CUR_WORD_BYTES;
            if (fcount == 3'(CUR_WORDS - 1)) begin
              cstate <= C_IDLE;
              cur_req_o <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // each word stores pattern 0 low, pattern 1 high
  for (genvar i = 0; i < CUR_WORDS; i++) begin : g_cur
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        cur_ram[i] <= '0;
      end else if (cstate == C_FETCH && cur_ack_i && fcount == 3'(i)) begin
        cur_ram[i] <= cursor_word_s'(cur_data_i);
      end
    end
  end

  // one fetch covers the next eight lines
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lines_left <= '0;
      rd_ptr <= '0;
    end else if (cstate == C_IDLE && hretrace_i && cfg[B_CURSOR] && cursor_hit_i
                 && lines_left == 4'h0) begin
      lines_left <= 4'(CUR_WORDS);
      rd_ptr <= '0;
    end else if (hretrace_i && lines_left != 4'h0 && cstate == C_IDLE) begin
      lines_left <= lines_left - 4'h1;
      rd_ptr <= rd_ptr + 3'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cur_line_o <= '0;
      cur_show_o <= 1'b0;
    end else begin
      cur_line_o <= cur_ram[rd_ptr];
      cur_show_o <= cfg[B_CURSOR] && lines_left != 4'h0 && cstate == C_IDLE;
    end
  end

  // polarity: set bit means active low input
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      vin_vsync_o <= 1'b0;
      vin_hsync_o <= 1'b0;
    end else begin
      vin_vsync_o <= vin_vsync_i ^ vinfmt[B_VS_POL];
      vin_hsync_o <= vin_hsync_i ^ vinfmt[B_HS_POL];
    end
  end

  // weave waits for the second field
  assign vin_frame_ev = vin_field_done_i && (!vinfmt[B_WEAVE] || weave_half);
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      weave_half <= 1'b0;
      vin_frame_o <= 1'b0;
    end else begin
      vin_frame_o <= vin_frame_ev;
      if (!vinfmt[B_WEAVE]) begin
        weave_half <= 1'b0;
      end else if (vin_field_done_i) begin
        weave_half <= !weave_half;
      end
    end
  end

  // status frame flag: write one clears, a new frame wins
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      frame_flag <= 1'b0;
    end else if (vin_frame_ev) begin
      frame_flag <= 1'b1;
    end else if (wr_i && addr_i == OFS_STATUS && wdata_i[ST_FRAME]) begin
      frame_flag <= 1'b0;
    end
  end

  property p_fetch_en;
    ##1 ctrl_o.ovl_fetch == $past(cfg[B_OVL_EN]) && ctrl_o.desk_fetch == $past(cfg[B_DESK_EN]);
  endproperty
  a_fetch_en: assert property (p_fetch_en) else $error("fetch enable mismatch");
  property p_vin_ovl;
    cfg[B_VIN_OVL] |=> ovl_addr_o == $past(vin_addr_i);
  endproperty
  a_vin_ovl: assert property (p_vin_ovl) else $error("video-in address not used");
  property p_clut;
    pix_is_ovl_i |=> clut_addr_o[8] == $past(cfg[B_OVL_HI]) && clut_bypass_o == $past(cfg[B_OVL_BYP]);
  endproperty
  a_clut: assert property (p_clut) else $error("overlay palette select wrong");
  property p_bob;
    cfg[B_BOB] && even_field_i && !cfg[B_TWO_PIX] |=> vofs_o == $past(vofs) + OFS_HALF;
  endproperty
  a_bob: assert property (p_bob) else $error("bob offset missing");
  property p_stereo_off;
    !cfg[B_STEREO] |=> !stereo_o;
  endproperty
  a_stereo_off: assert property (p_stereo_off) else $error("stereo pin high while off");
  property p_pair_hold;
    vretrace_i && cfg[B_STEREO] && !stereo_o |=> $stable(act_left) && $stable(act_right);
  endproperty
  a_pair_hold: assert property (p_pair_hold) else $error("pair changed after left field");
  property p_fetch8;
    cstate == C_FETCH && cur_ack_i && fcount == 3'h7 |=> !cur_req_o && cstate == C_IDLE;
  endproperty
  a_fetch8: assert property (p_fetch8) else $error("fetch did not end after eight words");
  property p_cur_off;
    !cfg[B_CURSOR] |=> !cur_show_o;
  endproperty
  a_cur_off: assert property (p_cur_off) else $error("cursor shown while disabled");
  property p_cur_start;
    cstate == C_IDLE && hretrace_i && cfg[B_CURSOR] && cursor_hit_i && lines_left == 4'h0
      |=> cur_req_o && lines_left == 4'h8;
  endproperty
  a_cur_start: assert property (p_cur_start) else $error("cursor fetch not started");
  property p_weave;
    vinfmt[B_WEAVE] && vin_field_done_i && !weave_half |=> !vin_frame_o;
  endproperty
  a_weave: assert property (p_weave) else $error("weave reported after one field");
  property p_pol;
    ##1 vin_vsync_o == ($past(vin_vsync_i) ^ $past(vinfmt[B_VS_POL]));
  endproperty
  a_pol: assert property (p_pol) else $error("vsync polarity wrong");
  c_swap: cover property (swap_i ##[1:20] vretrace_i && stereo_o);
  c_fetch: cover property (cstate == C_FETCH ##[1:40] cstate == C_IDLE);
  c_weave: cover property (vinfmt[B_WEAVE] && vin_frame_o);
endmodule

// ### cursor_memory_model.sv
// Purpose: cursor pattern memory on the far side of the fetch port
// Assumes: one word per acknowledge, request held until the eighth
// Notes: gap_i idle cycles between words, at least one, lets the bench act slow
`timescale 1ns/1ps
module cursor_memory_model (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic cur_req_i,
  input wire logic [25:0] cur_addr_i,
  input wire logic [3:0] gap_i,
  output logic cur_ack_o = 1'h0,
  output logic [127:0] cur_data_o = '0,
  output logic [3:0] burst_o = 4'h0,
  output logic [25:0] first_o = 26'h0,
  output logic [25:0] last_o = 26'h0
);
  logic [3:0] wait_q = 4'h0;
  always @(posedge mclk_i) begin
    if (reset_i) begin
      cur_ack_o <= 1'h0;
      wait_q <= 4'h0;
      burst_o <= 4'h0;
    end else begin
      if (cur_ack_o && cur_req_i) begin
        burst_o <= burst_o + 4'h1;
        last_o <= cur_addr_i;
        if (burst_o == 4'h0) begin
          first_o <= cur_addr_i;
        end
      end else if (!cur_req_i) begin
        burst_o <= 4'h0;
      end
      if (cur_req_i && !cur_ack_o && wait_q == 4'h0) begin
        cur_ack_o <= 1'h1;
        cur_data_o <= {~{38'h0, cur_addr_i}, 38'h0, cur_addr_i};
        wait_q <= gap_i;
      end else begin
        cur_ack_o <= 1'h0;
        // no word offered: toggle so stale data never looks valid
        cur_data_o <= ~cur_data_o;
        if (wait_q != 4'h0) begin
          wait_q <= wait_q - 4'h1;
        end
      end
    end
  end
endmodule

// ### video_refresh_surface_config_tb.sv
// Purpose: self-checking bench for the video refresh config block
// Assumes: read data stands one cycle after the read strobe
// Notes: reserved desktop formats expect zero bytes per pixel
`timescale 1ns/1ps
module video_refresh_surface_config_tb;
  import video_refresh_pkg::*;
  typedef struct {
    logic [31:0] cfg;
    logic [7:0] pix;
    logic ovl;
    refresh_ctrl_s ctrl;
    logic [9:0] clut;
  } row_s;
  logic mclk_i = 1'h0, reset_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, swap_i = 1'h0;
  logic vretrace_i = 1'h0, hretrace_i = 1'h0, even_field_i = 1'h0, pix_is_ovl_i = 1'h0;
  logic cursor_hit_i = 1'h0, vin_field_done_i = 1'h0, vin_vsync_i = 1'h0, vin_hsync_i = 1'h0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0, rdata_o, rd_val;
  logic [25:0] vin_addr_i = '0, ovl_addr_o, cur_addr_o, first_addr, last_addr;
  logic [7:0] pix_index_i = '0;
  logic [5:0] cursor_row_i = '0;
  logic [127:0] cur_data_i;
  logic [OFS_W-1:0] vofs_o;
  logic [8:0] clut_addr_o;
  logic cur_ack_i, clut_bypass_o, stereo_o, cur_req_o, cur_show_o;
  logic vin_vsync_o, vin_hsync_o, vin_frame_o;
  logic [3:0] gap = 4'h1, burst;
  refresh_ctrl_s ctrl_o;
  cursor_word_s cur_line_o;
  int n_fail = 0, checked = 0, n_frames = 0, f0;
  row_s rows[8];
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (vin_frame_o === 1'h1) n_frames <= n_frames + 1;
  video_refresh_surface_config dut_u (.mclk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .vretrace_i, .hretrace_i, .even_field_i, .swap_i, .vin_addr_i, .pix_index_i,
    .pix_is_ovl_i, .cursor_hit_i, .cursor_row_i, .cur_ack_i, .cur_data_i, .vin_field_done_i,
    .vin_vsync_i, .vin_hsync_i, .ctrl_o, .ovl_addr_o, .vofs_o, .clut_addr_o, .clut_bypass_o,
    .stereo_o, .cur_req_o, .cur_addr_o, .cur_line_o, .cur_show_o, .vin_vsync_o, .vin_hsync_o,
    .vin_frame_o);
  cursor_memory_model mem_u (.mclk_i, .reset_i, .cur_req_i(cur_req_o), .cur_addr_i(cur_addr_o),
    .gap_i(gap), .cur_ack_o(cur_ack_i), .cur_data_o(cur_data_i), .burst_o(burst),
    .first_o(first_addr), .last_o(last_addr));
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    cyc(1);
    wr_i <= 1'h0;
    cyc(1);
  endtask
  task automatic rd(input logic [11:0] a);
    addr_i <= a;
    rd_i <= 1'h1;
    cyc(1);
    rd_i <= 1'h0;
    cyc(1);
    rd_val = rdata_o;
  endtask
  task automatic pulse(input int k);
    case (k)
      0: vretrace_i <= 1'h1;
      1: hretrace_i <= 1'h1;
      2: swap_i <= 1'h1;
      default: vin_field_done_i <= 1'h1;
    endcase
    cyc(1);
    vretrace_i <= 1'h0;
    hretrace_i <= 1'h0;
    swap_i <= 1'h0;
    vin_field_done_i <= 1'h0;
    cyc(1);
  endtask
  task automatic vr_chk(input logic st, input logic [25:0] a);
    pulse(0);
    cyc(2);
    chk(128'(stereo_o), 128'(st), "stereo pin");
    chk(128'(ovl_addr_o), 128'(a), "overlay address");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic refresh_ctrl_s exp_ctrl(input logic [31:0] c);
    refresh_ctrl_s e;
    e = '0;
    {e.desk_fetch, e.ovl_fetch, e.h_scale, e.v_scale} = {c[7], c[8], c[14], c[15]};
    {e.desk_tiled, e.ovl_tiled, e.two_pix, e.cursor_on} = {c[24], c[25], c[26], c[27]};
    {e.desk_noopt, e.ovl_noopt} = {c[28], c[29]};
    e.filter = filter_e'(c[17:16]);
    e.desk_fmt = desk_fmt_e'(c[20:18]);
    e.desk_fmt_bad = c[20:18] > 3'h4;
    e.desk_bytes = (c[20:18] == 3'h0) ? 3'h1 : (c[20:18] == 3'h2) ? 3'h3 :
      (c[20:18] == 3'h3) ? 3'h4 : (c[20:18] > 3'h4) ? 3'h0 : 3'h2;
    e.ovl_fmt = ovl_fmt_e'(c[23:21]);
    e.ovl_yuv = c[23:21] inside {3'h4, 3'h5, 3'h6};
    return e;
  endfunction
  // long enough for every test with a wide margin
  initial begin
    cyc(20000);
    n_fail++;
    final_report();
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      logic [2:0] b;
      b = 3'(i);
      rows[i].cfg = {2'h0, ~b[0], b[0], b[1] ^ b[2], b[2], b[0], b[1], ~b, b, b[1:0], b[1],
        b[0], b[2], b[0] ^ b[1], b[2], b[1], 1'h0, ~b[0], b[0], 7'h00};
      rows[i].pix = {b, ~b, b[1:0]};
      rows[i].ovl = b[0];
      rows[i].ctrl = exp_ctrl(rows[i].cfg);
      rows[i].clut = {b[0] ? b[2] : b[1], b[0] ? b[2] : b[0] ^ b[1], rows[i].pix};
    end
    cyc(20);
    chk(128'({ctrl_o, stereo_o, cur_req_o}), 128'h0, "outputs in reset");
    reset_i <= 1'h0;
    cyc(1);
    chk(128'({ctrl_o, rdata_o}), 128'h0, "outputs after reset");
    rd(OFS_CFG);
    chk(128'(rd_val), 128'(CFG_RESET), "config reset");
    rd(OFS_VINFMT);
    chk(128'(rd_val), 128'(VINFMT_RESET), "input format reset");
    wr(12'hFF0, 32'hFFFF_FFFF);
    rd(12'hFF0);
    chk(128'(rd_val), 128'h0, "unmapped read");
    rd(OFS_CFG);
    chk(128'(rd_val), 128'(CFG_RESET), "unmapped write leak");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      refresh_ctrl_s g;
      pix_index_i <= rows[i].pix;
      pix_is_ovl_i <= rows[i].ovl;
      wr(OFS_CFG, rows[i].cfg);
      rd(OFS_CFG);
      g = ctrl_o;
      chk(128'(g), 128'(rows[i].ctrl), "control decode");
      chk(128'(rd_val), 128'(rows[i].cfg), "config readback");
      chk(128'({clut_bypass_o, clut_addr_o}), 128'(rows[i].clut), "palette path");
    end
    $display("test decode rows done");
    wr(OFS_CFG, 32'h0000_0100);
    wr(OFS_LEFT, 32'h0001_1110);
    pulse(0);
    pulse(2);
    vr_chk(1'h0, 26'h0011110);
    wr(OFS_CFG, 32'h0000_0104);
    wr(OFS_LEFT, 32'h0012_3450);
    wr(OFS_RIGHT, 32'h00AB_CDE0);
    pulse(2);
    pulse(0);
    cyc(2);
    chk(128'(stereo_o), 128'h1, "right field");
    vr_chk(1'h0, 26'h0123450);
    wr(OFS_LEFT, 32'h0055_5500);
    wr(OFS_RIGHT, 32'h0066_6600);
    pulse(2);
    vr_chk(1'h1, 26'h0ABCDE0);
    vr_chk(1'h0, 26'h0555500);
    vr_chk(1'h1, 26'h0666600);
    vin_addr_i <= 26'h2A5A5A0;
    wr(OFS_CFG, 32'h0000_0300);
    vr_chk(1'h0, 26'h2A5A5A0);
    $display("test stereo done");
    wr(OFS_VOFS, 32'h0000_0400);
    wr(OFS_VSTEP, 32'h0000_0800);
    for (int k = 0; k < 4; k++) begin
      even_field_i <= k[0];
      wr(OFS_CFG, 32'h8003_8100 | (k[1] ? 32'h0400_0000 : 32'h0));
      pulse(0);
      cyc(2);
      chk(128'(vofs_o), (k[0] && !k[1]) ? 128'hC00 : 128'h400, "bob offset");
    end
    $display("test bob done");
    wr(OFS_CURPAT, 32'h0000_1000);
    cursor_hit_i <= 1'h1;
    cursor_row_i <= 6'h08;
    wr(OFS_CFG, 32'h0);
    pulse(1);
    chk(128'(cur_req_o), 128'h0, "fetch while cursor off");
    wr(OFS_CFG, 32'h0800_0000);
    for (int p = 0; p < 2; p++) begin
      int n;
      gap <= p ? 4'h4 : 4'h1;
      pulse(1);
      chk(128'(cur_req_o), 128'h1, "fetch start");
      n = 0;
      while (cur_req_o === 1'h1 && n < 300) begin
        cyc(1);
        n++;
      end
      chk(128'(burst), 128'h8, "words fetched");
      chk(128'({first_addr, last_addr}), 128'({26'h0001080, 26'h00010F0}),
        "fetch addresses");
      for (int j = 0; j < 8; j++) begin
        cyc(1);
        chk(128'(cur_line_o), 128'({~{38'h0, 26'h0001080 + 26'(16 * j)}, 38'h0,
          26'h0001080 + 26'(16 * j)}), "cursor line");
        chk(128'(cur_show_o), 128'h1, "cursor shown");
        pulse(1);
        if (j < 7) chk(128'(cur_req_o), 128'h0, "fetch with lines left");
      end
      cyc(1);
      chk(128'(cur_show_o), 128'h0, "cursor after eight lines");
    end
    cursor_hit_i <= 1'h0;
    $display("test cursor done");
    wr(OFS_VINFMT, 32'h0);
    f0 = n_frames;
    repeat (3) pulse(3);
    cyc(2);
    chk(128'(n_frames - f0), 128'h3, "frames no weave");
    wr(OFS_VINFMT, 32'h10);
    f0 = n_frames;
    repeat (4) pulse(3);
    cyc(2);
    chk(128'(n_frames - f0), 128'h2, "frames weave");
    rd(OFS_STATUS);
    chk(128'(rd_val[0]), 128'h1, "frame flag set");
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS);
    chk(128'(rd_val[0]), 128'h0, "frame flag cleared");
    for (int k = 0; k < 16; k++) begin
      wr(OFS_VINFMT, 32'(k[1:0]) << 5);
      vin_vsync_i <= k[2];
      vin_hsync_i <= k[3];
      cyc(3);
      chk(128'({vin_vsync_o, vin_hsync_o}), 128'({k[2] ^ k[0], k[3] ^ k[1]}), "syncs");
    end
    // clear and new frame in one cycle: the frame must win
    addr_i <= OFS_STATUS;
    wdata_i <= 32'h1;
    wr_i <= 1'h1;
    vin_field_done_i <= 1'h1;
    cyc(1);
    wr_i <= 1'h0;
    vin_field_done_i <= 1'h0;
    cyc(1);
    rd(OFS_STATUS);
    chk(128'(rd_val[0]), 128'h1, "frame beats clear");
    $display("test video input done");
    final_report();
  end
endmodule
